// ===== rtl/amc_pkg.sv
// Constants and types of the mode control block
package amc_pkg;

    // Clock and timing
    localparam int AMC_CLK_HZ = 25_000_000;
    localparam int AMC_SETTLE_US = 2000;
    localparam int AMC_SETTLE_CYC =
        (AMC_SETTLE_US * (AMC_CLK_HZ / 1_000_000));
    localparam int AMC_TEMP_HZ = 100;
    localparam int AMC_TEMP_CYC = AMC_CLK_HZ / AMC_TEMP_HZ;

    // Register addresses (7-bit)
    localparam logic [6:0] AMC_ADDR_OPERATING_MODE_FIELD = 7'h26;
    localparam logic [6:0] AMC_ADDR_DIG_EN = 7'h27;
    localparam logic [6:0] AMC_ADDR_STATUS = 7'h28;
    localparam logic [6:0] AMC_ADDR_FIFO_CNT = 7'h29;
    localparam logic [6:0] AMC_ADDR_X_H = 7'h30;
    localparam logic [6:0] AMC_ADDR_X_L = 7'h31;
    localparam logic [6:0] AMC_ADDR_Y_H = 7'h32;
    localparam logic [6:0] AMC_ADDR_Y_L = 7'h33;
    localparam logic [6:0] AMC_ADDR_Z_H = 7'h34;
    localparam logic [6:0] AMC_ADDR_Z_L = 7'h35;
    localparam logic [6:0] AMC_ADDR_T_H = 7'h36;
    localparam logic [6:0] AMC_ADDR_T_L = 7'h37;
    localparam logic [6:0] AMC_ADDR_FIFO_H = 7'h3A;
    localparam logic [6:0] AMC_ADDR_FIFO_L = 7'h3B;

    // Field positions
    localparam int AMC_MODE_LSB = 0;
    localparam int AMC_RANGE_LSB = 4;
    localparam int AMC_TEMP_EN_BIT = 0;
    localparam int AMC_TEMP_FIFO_BIT = 1;
    localparam int AMC_ST_SETTLED_BIT = 0;
    localparam int AMC_ST_DSM_BIT = 1;
    localparam int AMC_ST_SAR_BIT = 2;
    localparam int AMC_ST_FULL_BIT = 3;
    localparam int AMC_ST_EMPTY_BIT = 4;

    // Reset values
    localparam logic [3:0] AMC_MODE_RST = 4'h0;
    localparam logic [1:0] AMC_RANGE_RST = 2'h0;
    localparam logic [1:0] AMC_DIG_EN_RST = 2'h0;

    // Operating mode codes; 7 to 15 are the nine concurrent pairs
    localparam logic [3:0] AMC_MODE_STANDBY = 4'h0;
    localparam logic [3:0] AMC_MODE_CONC_BASE = 4'h7;
    localparam logic [1:0] AMC_PATH_OFF = 2'h0;

    // Range codes; code 3 is reserved
    localparam logic [1:0] AMC_RANGE_15G = 2'h0;
    localparam logic [1:0] AMC_RANGE_30G = 2'h1;
    localparam logic [1:0] AMC_RANGE_60G = 2'h2;

    // Output buffer shape
    localparam int AMC_FIFO_WIDTH = 16;
    localparam int AMC_FIFO_DEPTH = 16;

    typedef enum logic [0:0] {
        AMC_CAP_IDLE = 1'b0,
        AMC_CAP_PUSH = 1'b1
    } amc_cap_t;

endpackage : amc_pkg

// ===== rtl/amc_mode_control.sv
// Accelerometer mode control: SPI registers, modes, capture and FIFO
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module amc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("FIFO depth must be a power of two, at least 2");
        end
    endgenerate

    // Handshake terms
    assign o_in_ready = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != '0);
    assign do_wr = i_in_valid & o_in_ready;
    assign do_rd = o_out_valid & i_out_ready;
    assign o_out_data = mem[rd_ptr];
    assign o_count = count;

    // Storage
    always_ff @(posedge i_ref_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : amc_fifo

//////////////////////////////////////////////////////////////////////////////
// Operation
// - After reset the block sits in standby with both paths switched off.
// - Standby stops capture, leaves the FIFO untouched and adds no events.
// - Standby plus three sigma-delta and three SAR modes are offered.
// - Concurrent codes run one sigma-delta and one SAR mode together.
// - The mode is taken from the operating-mode register at 0x26.
// - Ranges of 15, 30 or 60 g are selectable and drive the converters.
// - A 12-bit temperature reading exists and can be stored in the FIFO.
// - Temperature output updates with each accel sample unless disabled.
// - Temperature samples at 100 Hz and repeats the last value between.
// - Codes rise with positive acceleration; sign and order are kept.
// - Configuration and readout travel over the SPI port.
module amc_mode_control
    import amc_pkg::*;
#(
    parameter int SETTLE_CYC = AMC_SETTLE_CYC,
    parameter int TEMP_CYC = AMC_TEMP_CYC,
    parameter int FIFO_DEPTH = AMC_FIFO_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sdi,
    output logic o_spi_sdo,
    output logic o_spi_sdo_oe_n,
    output logic o_dsm_en,
    output logic [1:0] o_dsm_mode,
    output logic o_sar_en,
    output logic [1:0] o_sar_mode,
    output logic [1:0] o_range,
    input wire logic i_dsm_valid,
    output logic o_dsm_ready,
    input wire logic [15:0] i_dsm_x,
    input wire logic [15:0] i_dsm_y,
    input wire logic [15:0] i_dsm_z,
    input wire logic i_sar_valid,
    output logic o_sar_ready,
    input wire logic [11:0] i_sar_x,
    input wire logic [11:0] i_sar_y,
    input wire logic [11:0] i_sar_z,
    output logic o_temp_start,
    input wire logic i_temp_valid,
    input wire logic [11:0] i_temp_code,
    output logic o_settled
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    generate
        if (SETTLE_CYC < 1 || TEMP_CYC < 1 || SETTLE_CYC >= (1 << 24)
            || TEMP_CYC >= (1 << 24)) begin : g_bad_count
            $error("Timing counts must lie between 1 and 2**24-1");
        end
    endgenerate

    // Pin synchronisers
    logic sck_s1, sck_s2, sck_d, cs_s1, cs_s2, sdi_s1, sdi_s2;
    // SPI state
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [4:0] bit_cnt;
    logic [6:0] addr;
    logic rd_flag;
    logic [7:0] rdata;
    logic [7:0] fifo_lo;
    // Registers
    logic [3:0] mode;
    logic [1:0] range_sel;
    logic [1:0] dig_en;
    logic [15:0] data_x, data_y, data_z, data_t;
    logic [11:0] temp_latest;
    // Control
    logic [23:0] settle_cnt;
    logic [23:0] temp_cnt;
    logic [1:0] dsm_sel, sar_sel;
    amc_cap_t cap_state;
    logic [1:0] push_idx;
    logic [15:0] push_data;
    logic push_ready;
    logic fifo_valid;
    logic [15:0] fifo_data;
    logic [CW-1:0] fifo_cnt;
    logic sck_rise, sck_fall, cs_act, rd_load, wr_strobe, pop;
    logic measuring, take_dsm, take_sar, temp_on, last_word;

    //////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers, then a third stage for edges
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_d <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
        end else begin
            sck_s1 <= i_spi_sclk;
            sck_s2 <= sck_s1;
            sck_d <= sck_s2;
            cs_s1 <= i_spi_cs_n;
            cs_s2 <= cs_s1;
            sdi_s1 <= i_spi_sdi;
            sdi_s2 <= sdi_s1;
        end
    end

    // SPI frame decode: byte 0 is {addr, read}, byte 1 is data
    assign cs_act = ~cs_s2;
    assign sck_rise = cs_act & sck_s2 & ~sck_d;
    assign sck_fall = cs_act & ~sck_s2 & sck_d;
    assign rd_load = sck_rise & (bit_cnt == 5'd7) & sdi_s2;
    assign wr_strobe = sck_rise & (bit_cnt == 5'd15) & ~rd_flag;
    assign pop = rd_load & (rx_sh[6:0] == AMC_ADDR_FIFO_H) & fifo_valid;
    assign o_spi_sdo = tx_sh[7];
    assign o_spi_sdo_oe_n = ~(cs_act & rd_flag & (bit_cnt >= 5'd8));

    // Shift registers and bit counter
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_sh <= 8'h00;
            tx_sh <= 8'h00;
            bit_cnt <= 5'd0;
            addr <= 7'h00;
            rd_flag <= 1'b0;
        end else if (!cs_act) begin
            bit_cnt <= 5'd0;
            rd_flag <= 1'b0;
        end else begin
            if (sck_rise) begin
                rx_sh <= {rx_sh[6:0], sdi_s2};
                if (bit_cnt != 5'd16) begin
                    bit_cnt <= bit_cnt + 5'd1;
                end
                if (bit_cnt == 5'd7) begin
                    addr <= rx_sh[6:0];
                    rd_flag <= sdi_s2;
                end
            end
            if (rd_load) begin
                tx_sh <= rdata;
            end else if (sck_fall && bit_cnt >= 5'd9 && bit_cnt <= 5'd15) begin
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    // Read mux on the first byte as it completes
    always_comb begin
        rdata = 8'h00;
        unique case (rx_sh[6:0])
            AMC_ADDR_OPERATING_MODE_FIELD: rdata = {2'b00, range_sel, mode};
            AMC_ADDR_DIG_EN: rdata = {6'b000000, dig_en};
            AMC_ADDR_STATUS: begin
                rdata[AMC_ST_SETTLED_BIT] = o_settled;
                rdata[AMC_ST_DSM_BIT] = o_dsm_en;
                rdata[AMC_ST_SAR_BIT] = o_sar_en;
                rdata[AMC_ST_FULL_BIT] = ~push_ready;
                rdata[AMC_ST_EMPTY_BIT] = ~fifo_valid;
            end
            AMC_ADDR_FIFO_CNT: rdata = 8'(fifo_cnt);
            AMC_ADDR_X_H: rdata = data_x[15:8];
            AMC_ADDR_X_L: rdata = data_x[7:0];
            AMC_ADDR_Y_H: rdata = data_y[15:8];
            AMC_ADDR_Y_L: rdata = data_y[7:0];
            AMC_ADDR_Z_H: rdata = data_z[15:8];
            AMC_ADDR_Z_L: rdata = data_z[7:0];
            AMC_ADDR_T_H: rdata = data_t[15:8];
            AMC_ADDR_T_L: rdata = data_t[7:0];
            AMC_ADDR_FIFO_H: rdata = fifo_valid ? fifo_data[15:8] : 8'h00;
            AMC_ADDR_FIFO_L: rdata = fifo_lo;
            default: rdata = 8'h00;
        endcase
    end

    // Low byte of a popped word for the next read
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fifo_lo <= 8'h00;
        end else if (pop) begin
            fifo_lo <= fifo_data[7:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Writable registers; reset lands in standby
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode <= AMC_MODE_RST;
            range_sel <= AMC_RANGE_RST;
            dig_en <= AMC_DIG_EN_RST;
        end else if (wr_strobe) begin
            if (addr == AMC_ADDR_OPERATING_MODE_FIELD) begin
                mode <= {rx_sh[AMC_MODE_LSB +: 3], sdi_s2};
                if (rx_sh[AMC_RANGE_LSB-1 +: 2] != 2'h3) begin
                    range_sel <= rx_sh[AMC_RANGE_LSB-1 +: 2];
                end
            end
            if (addr == AMC_ADDR_DIG_EN) begin
                dig_en <= {rx_sh[0], sdi_s2};
            end
        end
    end

    // Mode code to path selections
    always_comb begin
        dsm_sel = AMC_PATH_OFF;
        sar_sel = AMC_PATH_OFF;
        if (mode == AMC_MODE_STANDBY) begin
            dsm_sel = AMC_PATH_OFF;
        end else if (mode <= 4'h3) begin
            dsm_sel = mode[1:0];
        end else if (mode <= 4'h6) begin
            sar_sel = 2'(mode - 4'h3);
        end else begin
            dsm_sel = 2'((mode - AMC_MODE_CONC_BASE) / 4'h3 + 4'h1);
            sar_sel = 2'((mode - AMC_MODE_CONC_BASE) % 4'h3 + 4'h1);
        end
    end

    assign o_dsm_en = (dsm_sel != AMC_PATH_OFF);
    assign o_sar_en = (sar_sel != AMC_PATH_OFF);
    assign o_dsm_mode = dsm_sel;
    assign o_sar_mode = sar_sel;
    assign o_range = range_sel;
    assign measuring = o_dsm_en | o_sar_en;
    assign temp_on = measuring & dig_en[AMC_TEMP_EN_BIT];

    // Settling countdown after a mode write
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            settle_cnt <= 24'd0;
            o_settled <= 1'b0;
        end else if (!measuring) begin
            settle_cnt <= 24'(SETTLE_CYC - 1);
            o_settled <= 1'b0;
        end else if (wr_strobe && addr == AMC_ADDR_OPERATING_MODE_FIELD) begin
            settle_cnt <= 24'(SETTLE_CYC - 1);
            o_settled <= 1'b0;
        end else if (settle_cnt != 24'd0) begin
            settle_cnt <= settle_cnt - 24'd1;
        end else begin
            o_settled <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Temperature pacing and latest value
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            temp_cnt <= 24'd0;
            o_temp_start <= 1'b0;
            temp_latest <= 12'h000;
        end else begin
            o_temp_start <= temp_on && temp_cnt == 24'd0;
            if (!temp_on) begin
                temp_cnt <= 24'd0;
            end else if (temp_cnt == 24'(TEMP_CYC - 1)) begin
                temp_cnt <= 24'd0;
            end else begin
                temp_cnt <= temp_cnt + 24'd1;
            end
            if (i_temp_valid) begin
                temp_latest <= i_temp_code;
            end
        end
    end

    // Sample acceptance; none in standby
    assign o_dsm_ready = measuring & (cap_state == AMC_CAP_IDLE);
    assign o_sar_ready = o_dsm_ready & ~(i_dsm_valid & o_dsm_en);
    assign take_dsm = i_dsm_valid & o_dsm_ready & o_dsm_en;
    assign take_sar = i_sar_valid & o_sar_ready & o_sar_en;

    // Output registers; held through standby
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            data_x <= 16'h0000;
            data_y <= 16'h0000;
            data_z <= 16'h0000;
            data_t <= 16'h0000;
        end else if (take_dsm || take_sar) begin
            if (take_dsm) begin
                data_x <= i_dsm_x;
                data_y <= i_dsm_y;
                data_z <= i_dsm_z;
            end else begin
                data_x <= {i_sar_x, 4'h0};
                data_y <= {i_sar_y, 4'h0};
                data_z <= {i_sar_z, 4'h0};
            end
            if (dig_en[AMC_TEMP_EN_BIT]) begin
                data_t <= {4'h0, temp_latest};
            end
        end
    end

    // Push x, y, z, then temperature when routed to the FIFO
    assign last_word = (push_idx == 2'd3) || (push_idx == 2'd2 &&
        !(dig_en[AMC_TEMP_FIFO_BIT] && dig_en[AMC_TEMP_EN_BIT]));
    always_comb begin
        unique case (push_idx)
            2'd0: push_data = data_x;
            2'd1: push_data = data_y;
            2'd2: push_data = data_z;
            2'd3: push_data = data_t;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cap_state <= AMC_CAP_IDLE;
            push_idx <= 2'd0;
        end else begin
            unique case (cap_state)
                AMC_CAP_IDLE: begin
                    if (take_dsm || take_sar) begin
                        cap_state <= AMC_CAP_PUSH;
                        push_idx <= 2'd0;
                    end
                end
                AMC_CAP_PUSH: begin
                    if (push_ready) begin
                        if (last_word) begin
                            cap_state <= AMC_CAP_IDLE;
                        end else begin
                            push_idx <= push_idx + 2'd1;
                        end
                    end
                end
            endcase
        end
    end

    // Output FIFO; full stalls the sequencer and converters
    amc_fifo #(
        .WIDTH(AMC_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(cap_state == AMC_CAP_PUSH),
        .o_in_ready(push_ready),
        .i_in_data(push_data),
        .o_out_valid(fifo_valid),
        .i_out_ready(pop),
        .o_out_data(fifo_data),
        .o_count(fifo_cnt)
    );
endmodule : amc_mode_control

// ===== tb/amc_mode_control_monitor.sv
// Port checker of the mode control block
`timescale 1ns/1ns
module amc_mode_control_monitor
    import amc_pkg::*;
#(
    parameter int SETTLE_CYC = AMC_SETTLE_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_spi_cs_n,
    input wire logic o_spi_sdo_oe_n,
    input wire logic o_dsm_en,
    input wire logic [1:0] o_dsm_mode,
    input wire logic o_sar_en,
    input wire logic [1:0] o_sar_mode,
    input wire logic [1:0] o_range,
    input wire logic i_dsm_valid,
    input wire logic o_dsm_ready,
    input wire logic o_sar_ready,
    input wire logic o_temp_start,
    input wire logic o_settled
);
    int meas_cnt;
    logic meas;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    // Any path running
    assign meas = o_dsm_en | o_sar_en;

    // Cycles in one unchanged setting
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meas_cnt <= 0;
        end else if (!meas || $changed({o_dsm_mode, o_sar_mode, o_range})) begin
            meas_cnt <= 0;
        end else if (meas_cnt < SETTLE_CYC + 16) begin
            meas_cnt <= meas_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample take and push
    sequence dsm_take;
        i_dsm_valid && o_dsm_ready;
    endsequence
    sequence push_quiet;
        (!o_dsm_ready && !o_sar_ready) [*3];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    standby_ready_a: assert property (!meas |-> !o_dsm_ready && !o_sar_ready)
        else $error("ready in standby");
    dsm_encode_a: assert property (o_dsm_en == (o_dsm_mode != 2'h0))
        else $error("dsm enable mismatch");
    sar_encode_a: assert property (o_sar_en == (o_sar_mode != 2'h0))
        else $error("sar enable mismatch");
    range_legal_a: assert property (o_range != 2'h3)
        else $error("reserved range");
    dsm_wins_a: assert property (i_dsm_valid && o_dsm_en |-> !o_sar_ready)
        else $error("sar ready against dsm");
    push_hold_a: assert property (dsm_take |=> push_quiet)
        else $error("ready during push");
    settle_early_a: assert property (o_settled |-> meas_cnt >= SETTLE_CYC - 2)
        else $error("settled early");
    settle_late_a: assert property (meas_cnt == SETTLE_CYC + 8 |-> o_settled)
        else $error("settled late");
    standby_unsettled_a: assert property (!meas |=> !o_settled)
        else $error("settled in standby");
    temp_pulse_a: assert property (o_temp_start |=> !o_temp_start)
        else $error("temp start too long");
    temp_meas_a: assert property (o_temp_start |-> meas)
        else $error("temp start in standby");
    sdo_release_a: assert property ($rose(i_spi_cs_n) |-> ##[1:6] o_spi_sdo_oe_n)
        else $error("sdo not released");
endmodule : amc_mode_control_monitor

bind amc_mode_control amc_mode_control_monitor #(
    .SETTLE_CYC(SETTLE_CYC)
) mon (.i_ref_clk, .i_sys_rst, .i_spi_cs_n, .o_spi_sdo_oe_n, .o_dsm_en,
    .o_dsm_mode, .o_sar_en, .o_sar_mode, .o_range, .i_dsm_valid,
    .o_dsm_ready, .o_sar_ready, .o_temp_start, .o_settled);

// ===== tb/amc_conv_model.sv
// Model of the converters feeding the block
`timescale 1ns/1ns
module amc_conv_model (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_dsm_req,
    input wire logic i_sar_req,
    input wire logic [47:0] i_xyz,
    input wire logic [11:0] i_tcode,
    input wire logic i_dsm_ready,
    input wire logic i_sar_ready,
    input wire logic i_temp_start,
    output logic o_dsm_valid,
    output logic o_sar_valid,
    output logic [47:0] o_xyz,
    output logic o_temp_valid,
    output logic [11:0] o_temp_code
);
    logic [3:0] t_pipe;

    // Offer held until taken; idle data toggles
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_dsm_valid <= 1'b0;
            o_sar_valid <= 1'b0;
            o_xyz <= 48'h0;
        end else begin
            if (i_dsm_req) begin
                o_dsm_valid <= 1'b1;
            end else if (i_dsm_ready) begin
                o_dsm_valid <= 1'b0;
            end
            if (i_sar_req) begin
                o_sar_valid <= 1'b1;
            end else if (i_sar_ready) begin
                o_sar_valid <= 1'b0;
            end
            if (i_dsm_req || i_sar_req) begin
                o_xyz <= i_xyz;
            end else if (!o_dsm_valid && !o_sar_valid) begin
                o_xyz <= ~o_xyz;
            end
        end
    end

    // Temperature answer after each start
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            t_pipe <= 4'h0;
            o_temp_valid <= 1'b0;
            o_temp_code <= 12'h000;
        end else begin
            t_pipe <= {t_pipe[2:0], i_temp_start};
            o_temp_valid <= t_pipe[3];
            o_temp_code <= t_pipe[3] ? i_tcode : ~o_temp_code;
        end
    end
endmodule : amc_conv_model

// ===== tb/amc_mode_control_tb.sv
// Testbench of the mode control block
`timescale 1ns/1ns
module amc_mode_control_tb;
    import amc_pkg::*;
    localparam int SETTLE = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclk = 1'b0;
    logic cs_n = 1'b1;
    logic sdi = 1'b0;
    logic dreq = 1'b0;
    logic sreq = 1'b0;
    logic [47:0] bxyz = 48'h0;
    logic [11:0] btc = 12'h000;
    logic sdo, oe_n, dsm_en, sar_en, dv, dr, sv, sr, ts, tv, settled;
    logic [1:0] dsm_mode, sar_mode, range;
    logic [47:0] cxyz;
    logic [11:0] tc;
    logic [7:0] q;
    logic [15:0] word, keep;
    logic [15:0] expq[$];
    int fails = 0;
    int compares = 0;
    int n;

    // 25 MHz reference clock
    always #20 clk = ~clk;

    amc_mode_control #(.SETTLE_CYC(SETTLE), .TEMP_CYC(50)) uut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_spi_sclk(sclk),
        .i_spi_cs_n(cs_n), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
        .o_spi_sdo_oe_n(oe_n), .o_dsm_en(dsm_en), .o_dsm_mode(dsm_mode),
        .o_sar_en(sar_en), .o_sar_mode(sar_mode), .o_range(range),
        .i_dsm_valid(dv), .o_dsm_ready(dr), .i_dsm_x(cxyz[47:32]),
        .i_dsm_y(cxyz[31:16]), .i_dsm_z(cxyz[15:0]), .i_sar_valid(sv),
        .o_sar_ready(sr), .i_sar_x(cxyz[47:36]), .i_sar_y(cxyz[31:20]),
        .i_sar_z(cxyz[15:4]), .o_temp_start(ts), .i_temp_valid(tv),
        .i_temp_code(tc), .o_settled(settled));

    amc_conv_model conv (.i_ref_clk(clk), .i_sys_rst(rst),
        .i_dsm_req(dreq), .i_sar_req(sreq), .i_xyz(bxyz), .i_tcode(btc),
        .i_dsm_ready(dr), .i_sar_ready(sr), .i_temp_start(ts),
        .o_dsm_valid(dv), .o_sar_valid(sv), .o_xyz(cxyz),
        .o_temp_valid(tv), .o_temp_code(tc));

    ////////////////////////////////////////////////////////////////////////
    // Expected {enable, path} of one side for a mode byte
    function automatic logic [2:0] exp_path(input int c, input bit sar);
        int m = c % 16;
        int i = m - 7;
        if (m >= 7) return {1'b1, 2'(sar ? i % 3 + 1 : i / 3 + 1)};
        if (sar ? m >= 4 && m <= 6 : m >= 1 && m <= 3)
            return {1'b1, 2'(sar ? m - 3 : m)};
        return 3'h0;
    endfunction : exp_path

    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One SPI mode 0 frame, read byte left in q
    task automatic spi(input logic [6:0] a, input logic r, input logic [7:0] d);
        logic [15:0] sh;
        sh = {a, r, d};
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            sdi = sh[i];
            repeat (5) @(negedge clk);
            if (i < 8) q[i] = sdo;
            sclk = 1'b1;
            repeat (5) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (5) @(negedge clk);
        cs_n = 1'b1;
        sdi = ~sdi;
        repeat (5) @(negedge clk);
    endtask : spi

    task automatic rd16(input logic [6:0] a);
        spi(a, 1'b1, 8'h00);
        word[15:8] = q;
        spi(a + 7'h1, 1'b1, 8'h00);
        word[7:0] = q;
    endtask : rd16

    task automatic offer(input logic dsm);
        dreq = dsm;
        sreq = !dsm;
        @(negedge clk);
        dreq = 1'b0;
        sreq = 1'b0;
    endtask : offer

    task automatic wait_for(input bit s);
        for (n = 0; n < 300; n++) begin
            if (s ? settled === 1'b1 : {dv, sv} === 2'b00) return;
            @(negedge clk);
        end
        fails++;
        complete_run();
    endtask : wait_for

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'hEE75));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("paths", {13'h0, dsm_en, sar_en, settled}, 16'h0);
        check("oe_n", {15'h0, oe_n}, 16'h1);
        // All mode and range codes from standby
        for (int c = 0; c < 64; c++) begin
            spi(AMC_ADDR_OPERATING_MODE_FIELD, 1'b0, 8'h00);
            spi(AMC_ADDR_OPERATING_MODE_FIELD, 1'b0, 8'(c));
            check("dsm", {13'h0, dsm_en, dsm_mode}, 16'(exp_path(c, 0)));
            check("sar", {13'h0, sar_en, sar_mode}, 16'(exp_path(c, 1)));
            check("range", 16'(range), 16'(c / 16 == 3 ? 0 : c / 16));
            spi(AMC_ADDR_OPERATING_MODE_FIELD, 1'b1, 8'h00);
            check("operating_mode_field", 16'(q), 16'(c / 16 == 3 ? c % 16 : c));
        end
        // Temperature to FIFO, filled past full
        spi(AMC_ADDR_OPERATING_MODE_FIELD, 1'b0, 8'h00);
        spi(AMC_ADDR_DIG_EN, 1'b0, 8'h03);
        btc = 12'($urandom);
        spi(AMC_ADDR_OPERATING_MODE_FIELD, 1'b0, 8'h01);
        wait_for(1);
        for (int s = 0; s < 5; s++) begin
            bxyz = s == 0 ? 48'h7FFF_8000_0001 : {$urandom, 16'($urandom)};
            expq.push_back(bxyz[47:32]);
            expq.push_back(bxyz[31:16]);
            expq.push_back(bxyz[15:0]);
            expq.push_back({4'h0, btc});
            offer(1'b1);
            wait_for(0);
        end
        repeat (10) @(negedge clk);
        spi(AMC_ADDR_STATUS, 1'b1, 8'h00);
        check("full", 16'(q[AMC_ST_FULL_BIT]), 16'h1);
        rd16(AMC_ADDR_X_H);
        check("x", word, bxyz[47:32]);
        rd16(AMC_ADDR_T_H);
        check("temp", word, {4'h0, btc});
        while (expq.size() > 0) begin
            rd16(AMC_ADDR_FIFO_H);
            check("fifo", word, expq.pop_front());
        end
        spi(AMC_ADDR_FIFO_H, 1'b1, 8'h00);
        check("empty", 16'(q), 16'h0);
        // Standby refuses samples, keeps data
        keep = bxyz[47:32];
        spi(AMC_ADDR_OPERATING_MODE_FIELD, 1'b0, 8'h00);
        bxyz = ~bxyz;
        offer(1'b1);
        repeat (20) @(negedge clk);
        check("held", {15'h0, dv}, 16'h1);
        rd16(AMC_ADDR_X_H);
        check("x_keep", word, keep);
        spi(AMC_ADDR_OPERATING_MODE_FIELD, 1'b0, 8'h01);
        wait_for(0);
        // SAR path stores 12 bits left aligned
        spi(AMC_ADDR_OPERATING_MODE_FIELD, 1'b0, 8'h00);
        spi(AMC_ADDR_OPERATING_MODE_FIELD, 1'b0, 8'h24);
        wait_for(1);
        bxyz = {$urandom, 16'($urandom)};
        offer(1'b0);
        wait_for(0);
        rd16(AMC_ADDR_X_H);
        check("sar_x", word, {bxyz[47:36], 4'h0});
        spi(7'h7F, 1'b1, 8'h00);
        check("unmapped", 16'(q), 16'h0);
        complete_run();
    end
endmodule : amc_mode_control_tb
